/* hw/gicl_params.svh */
// Purpose: constants for the gated input capture latch bank
// Assumes: included by the package and by every design file
// Notes: offsets are byte addresses on a 32-bit register bus
`ifndef GICL_PARAMS_SVH
`define GICL_PARAMS_SVH

// ***************************************************************
// widths
// ***************************************************************
`define GICL_BANK_W 4
`define GICL_ADDR_W 8
`define GICL_DATA_W 32
`define GICL_CNT_W 16

// ***************************************************************
// register offsets
// ***************************************************************
`define GICL_OFF_CTRL 8'h00
`define GICL_OFF_STATUS 8'h04
`define GICL_OFF_PAD 8'h08
`define GICL_OFF_COUNT 8'h0C

// ***************************************************************
// control fields
// ***************************************************************
`define GICL_CTRL_LOW_GATE 0
`define GICL_CTRL_PRESET 1
`define GICL_CTRL_STB_INV 2
`define GICL_CTRL_SOFT_INIT 3
`define GICL_CTRL_LOW_GATE_RST 1'b0
`define GICL_CTRL_STB_INV_RST 1'b0

// ***************************************************************
// status fields
// ***************************************************************
`define GICL_ST_LEVEL_LSB 0
`define GICL_ST_EDGE_LSB 4
`define GICL_ST_GATE 8
`define GICL_ST_GATE_EN 9
`define GICL_ST_OPEN 10

// ***************************************************************
// bus answers and fillers
// ***************************************************************
`define GICL_RESP_OKAY 2'b00
`define GICL_RESP_SLVERR 2'b10
`define GICL_ZERO32 32'h0000_0000
`define GICL_CNT_ZERO 16'h0000
`define GICL_CNT_ONE 16'h0001
`define GICL_BANK_ZERO 4'h0

`endif

/* hw/gicl_pkg.sv */
// Purpose: shared types for the gated input capture latch bank
// Assumes: gicl_params.svh supplies every width but the strobe and response widths
// Notes: bus bundles follow the published AXI4-Lite signal names
`include "gicl_params.svh"

package gicl_pkg;

   // ************************************************************
   // register bus bundles
   // ************************************************************
   typedef struct packed {
      logic awvalid;
      logic [`GICL_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [`GICL_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`GICL_ADDR_W-1:0] araddr;
      logic rready;
   } gicl_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [`GICL_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } gicl_axil_rsp_t;

   // ************************************************************
   // pad side and control bundles
   // ************************************************************
   typedef struct packed {
      logic gate;
      logic gate_enable_in;
      logic [`GICL_BANK_W-1:0] data;
   } gicl_pad_t;

   typedef struct packed {
      logic strobe_inv;
      logic preset;
      logic low_gate;
   } gicl_ctrl_t;

endpackage

/* hw/gicl_latch_cell.sv */
// Purpose: one bit of the capture bank, level view and edge view
// Assumes: gate events already decoded by the bank
// Notes: clocked model of a transparent latch, one cycle late
`timescale 1ns/1ps
`include "gicl_params.svh"

module gicl_latch_cell #(
   parameter bit INIT_VAL = 1'b0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // control
   input wire logic init_hit,
   input wire logic init_val,
   input wire logic open_now,
   input wire logic closing,
   // data
   input wire logic d,
   output logic level_q,
   output logic edge_q
);

   // ************************************************************
   // level view
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= INIT_VAL;                     // [RL3] [RL4]
      end else if (ce) begin
         if (init_hit) begin
            level_q <= init_val;                  // [RL5]
         end else if (open_now || closing) begin
            // closing cycle loads too: value at the gate edge wins
            level_q <= d;                         // [RL1] [RL2] [RL12]
         end
      end
   end

   // ************************************************************
   // edge view
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_q <= INIT_VAL;
      end else if (ce) begin
         if (init_hit) begin
            edge_q <= init_val;                   // [RL5]
         end else if (closing) begin
            edge_q <= d;                          // [RL7] [RL8] [RL9]
         end
      end
   end

endmodule

/* hw/gicl_axil_port.sv */
// Purpose: AXI4-Lite slave front end for the capture bank
// Assumes: one write and one read outstanding at most
// Notes: address and data may arrive in either order
`timescale 1ns/1ps
`include "gicl_params.svh"

module gicl_axil_port (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // bus
   input wire gicl_pkg::gicl_axil_req_t req,
   output gicl_pkg::gicl_axil_rsp_t rsp,
   // register side
   output logic wr_en,
   output logic [`GICL_ADDR_W-1:0] wr_addr,
   output logic [`GICL_DATA_W-1:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [`GICL_ADDR_W-1:0] rd_addr,
   input wire logic [`GICL_DATA_W-1:0] rd_data,
   input wire logic rd_ok
);

   logic aw_take;
   logic w_take;
   logic b_take;
   logic ar_take;
   logic r_take;

   assign aw_take = req.awvalid && rsp.awready;
   assign w_take = req.wvalid && rsp.wready;
   assign b_take = rsp.bvalid && req.bready;
   assign ar_take = req.arvalid && rsp.arready;
   assign r_take = rsp.rvalid && req.rready;
   // both halves held, response not yet raised
   assign wr_en = !rsp.awready && !rsp.wready && !rsp.bvalid;
   assign rd_addr = req.araddr;

   // ************************************************************
   // write address and data
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp.awready <= 1'b1;
         wr_addr <= `GICL_OFF_CTRL;
      end else if (ce) begin
         if (aw_take) begin
            rsp.awready <= 1'b0;
            wr_addr <= req.awaddr;
         end else if (b_take) begin
            rsp.awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp.wready <= 1'b1;
         wr_data <= `GICL_ZERO32;
         wr_strb <= 4'h0;
      end else if (ce) begin
         if (w_take) begin
            rsp.wready <= 1'b0;
            wr_data <= req.wdata;
            wr_strb <= req.wstrb;
         end else if (b_take) begin
            rsp.wready <= 1'b1;
         end
      end
   end

   // ************************************************************
   // write response
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp.bvalid <= 1'b0;
         rsp.bresp <= `GICL_RESP_OKAY;
      end else if (ce) begin
         if (wr_en) begin
            rsp.bvalid <= 1'b1;
            rsp.bresp <= wr_ok ? `GICL_RESP_OKAY : `GICL_RESP_SLVERR;
         end else if (b_take) begin
            rsp.bvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // read channel
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp.arready <= 1'b1;
         rsp.rvalid <= 1'b0;
         rsp.rdata <= `GICL_ZERO32;
         rsp.rresp <= `GICL_RESP_OKAY;
      end else if (ce) begin
         if (ar_take) begin
            rsp.arready <= 1'b0;
            rsp.rvalid <= 1'b1;
            rsp.rdata <= rd_data;
            rsp.rresp <= rd_ok ? `GICL_RESP_OKAY : `GICL_RESP_SLVERR;
         end else if (r_take) begin
            rsp.arready <= 1'b1;
            rsp.rvalid <= 1'b0;
         end
      end
   end

endmodule

/* hw/gicl_bank.sv */
// Purpose: gated input capture latch bank with register access
// Assumes: pad inputs synchronous to aclk, no input buffer stage
// Notes: gate polarity, power-on value and strobe sense are set
//        by software; power-on value at reset is a parameter
`timescale 1ns/1ps
`include "gicl_params.svh"

// Notes on behaviour
// [RL1] inverted gate: low gate with enable high makes output follow data
// [RL2] inverted gate: data at the rising gate edge is captured and held
// [RL3] preset variant powers up with every output high
// [RL4] clear and enabled variants power up with every output low
// [RL5] init strobe returns every bit to its power-on value
// [RL6] init strobe active high, sense flipped by an inverter select
// [RL7] each bit offers a level view and a gate edge view
// [RL8] high-transparent latch pairs with falling-edge register
// [RL9] low-transparent latch pairs with rising-edge register
// [RL10] four bits share one gate and one enable, each independent
// [RL11] enable low holds outputs whatever gate and data do
// [RL12] normal gate: follow data while high, keep value at the fall
module gicl_bank #(
   parameter bit PRESET_VARIANT = 1'b0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // register bus
   input wire gicl_pkg::gicl_axil_req_t axil_req,
   output gicl_pkg::gicl_axil_rsp_t axil_rsp,
   // pad side
   input wire gicl_pkg::gicl_pad_t input_pad,
   input wire logic global_init_strobe,
   // captured views
   output logic [`GICL_BANK_W-1:0] level_q,
   output logic [`GICL_BANK_W-1:0] edge_q
);

   // ************************************************************
   // decoding helpers
   // ************************************************************
   function automatic logic addr_known(
      input logic [`GICL_ADDR_W-1:0] a
   );
      addr_known = (a == `GICL_OFF_CTRL) || (a == `GICL_OFF_STATUS) ||
                   (a == `GICL_OFF_PAD) || (a == `GICL_OFF_COUNT);
   endfunction

   function automatic logic gate_active(
      input logic g,
      input logic low_gate
   );
      gate_active = low_gate ? !g : g;
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************
   gicl_pkg::gicl_ctrl_t ctrl_reg;
   logic soft_init_reg;
   logic open_prev_reg;
   logic [`GICL_CNT_W-1:0] count_reg;
   logic [`GICL_CNT_W-1:0] count_next;
   logic wr_en;
   logic [`GICL_ADDR_W-1:0] wr_addr;
   logic [`GICL_DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic [`GICL_ADDR_W-1:0] rd_addr;
   logic [`GICL_DATA_W-1:0] rd_data;
   logic open_now;
   logic was_open;
   logic closing;
   logic init_hit;
   logic strobe_seen;

   // ************************************************************
   // register bus slave
   // ************************************************************
   gicl_axil_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .req(axil_req),
      .rsp(axil_rsp),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(addr_known(wr_addr)),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(addr_known(rd_addr))
   );

   // ************************************************************
   // control register
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg.low_gate <= `GICL_CTRL_LOW_GATE_RST;
         ctrl_reg.preset <= PRESET_VARIANT;
         ctrl_reg.strobe_inv <= `GICL_CTRL_STB_INV_RST;
      end else if (ce) begin
         if (wr_en && wr_addr == `GICL_OFF_CTRL && wr_strb[0]) begin
            ctrl_reg.low_gate <= wr_data[`GICL_CTRL_LOW_GATE];
            ctrl_reg.preset <= wr_data[`GICL_CTRL_PRESET];
            ctrl_reg.strobe_inv <= wr_data[`GICL_CTRL_STB_INV];
         end
      end
   end

   // software init: one cycle pulse, self clearing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_init_reg <= 1'b0;
      end else if (ce) begin
         soft_init_reg <= wr_en && wr_addr == `GICL_OFF_CTRL &&
                          wr_strb[0] && wr_data[`GICL_CTRL_SOFT_INIT];
      end
   end

   // ************************************************************
   // gate event decode
   // ************************************************************
   // strobe sense flip stands in for the inverter at the startup element
   assign strobe_seen = global_init_strobe ^ ctrl_reg.strobe_inv; // [RL6]
   assign init_hit = strobe_seen || soft_init_reg;                // [RL5]
   // enable low blocks both opening and closing, so nothing moves
   assign open_now = input_pad.gate_enable_in &&
                     gate_active(input_pad.gate, ctrl_reg.low_gate);
   // latch state, not gate level: a fall under enable low is no edge
   assign was_open = open_prev_reg;
   assign closing = input_pad.gate_enable_in && was_open &&
                    !gate_active(input_pad.gate, ctrl_reg.low_gate);
   // [RL11]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_prev_reg <= 1'b0;
      end else if (ce) begin
         open_prev_reg <= open_now;               // [RL11]
      end
   end

   // ************************************************************
   // latch bank
   // ************************************************************
   // one shared gate and enable, one cell per pad bit
   genvar gi;
   generate
      for (gi = 0; gi < `GICL_BANK_W; gi++) begin : g_cell
         gicl_latch_cell #(
            .INIT_VAL(PRESET_VARIANT)
         ) u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .init_hit(init_hit),
            .init_val(ctrl_reg.preset),
            .open_now(open_now),
            .closing(closing),
            .d(input_pad.data[gi]),
            .level_q(level_q[gi]),
            .edge_q(edge_q[gi])
         );                                       // [RL10]
      end
   endgenerate

   // ************************************************************
   // capture counter
   // ************************************************************
   // counts closing gate edges not under init; a closing edge in the clearing cycle
   // is kept, so software never loses one
   always_comb begin
      count_next = count_reg;
      if (wr_en && wr_addr == `GICL_OFF_COUNT) begin
         count_next = `GICL_CNT_ZERO;
      end
      if (closing && !init_hit) begin
         count_next = count_next + `GICL_CNT_ONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= `GICL_CNT_ZERO;
      end else if (ce) begin
         count_reg <= count_next;
      end
   end

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb begin
      rd_data = `GICL_ZERO32;
      unique case (rd_addr)
         `GICL_OFF_CTRL: begin
            rd_data[`GICL_CTRL_LOW_GATE] = ctrl_reg.low_gate;
            rd_data[`GICL_CTRL_PRESET] = ctrl_reg.preset;
            rd_data[`GICL_CTRL_STB_INV] = ctrl_reg.strobe_inv;
         end
         `GICL_OFF_STATUS: begin
            rd_data[`GICL_ST_LEVEL_LSB +: `GICL_BANK_W] = level_q;
            rd_data[`GICL_ST_EDGE_LSB +: `GICL_BANK_W] = edge_q;
            rd_data[`GICL_ST_GATE] = input_pad.gate;
            rd_data[`GICL_ST_GATE_EN] = input_pad.gate_enable_in;
            rd_data[`GICL_ST_OPEN] = open_now;
         end
         `GICL_OFF_PAD: begin
            rd_data[`GICL_BANK_W-1:0] = input_pad.data;
         end
         `GICL_OFF_COUNT: begin
            rd_data[`GICL_CNT_W-1:0] = count_reg;
         end
         default: begin
            rd_data = `GICL_ZERO32;
         end
      endcase
   end

endmodule

/* tb/gicl_bank_assertions.sv */
// Purpose: port checker for the gated input capture latch bank
// Assumes: writes carry address and data together, full strobes
// Notes: shadows the control word from bus traffic at the ports
`timescale 1ns/1ps
`include "gicl_params.svh"

module gicl_bank_assertions #(
   parameter bit PRESET_VARIANT = 1'b0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // register bus
   input wire gicl_pkg::gicl_axil_req_t axil_req,
   input wire gicl_pkg::gicl_axil_rsp_t axil_rsp,
   // pad side
   input wire gicl_pkg::gicl_pad_t input_pad,
   input wire logic global_init_strobe,
   // captured views
   input wire logic [`GICL_BANK_W-1:0] level_q,
   input wire logic [`GICL_BANK_W-1:0] edge_q
);
   // ***********************************************************
   // control shadow
   // ***********************************************************
   logic low_reg, preset_reg, inv_reg, aw_reg, w_reg, act_prev_reg, soft_reg;
   logic [`GICL_ADDR_W-1:0] addr_reg;
   logic [`GICL_DATA_W-1:0] data_reg;
   logic act, init, aw_hit, w_hit;
   assign act = input_pad.gate_enable_in & (input_pad.gate ^ low_reg);
   assign init = (global_init_strobe ^ inv_reg) | soft_reg;
   assign aw_hit = axil_req.awvalid & axil_rsp.awready;
   assign w_hit = axil_req.wvalid & axil_rsp.wready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         addr_reg <= '0;
         soft_reg <= 1'b0;
         data_reg <= '0;
      end else if (ce) begin
         // software init pulse follows the control write by one edge
         soft_reg <= aw_reg && w_reg && !axil_rsp.bvalid &&
                     addr_reg == `GICL_OFF_CTRL &&
                     data_reg[`GICL_CTRL_SOFT_INIT];
         if (aw_hit) begin
            aw_reg <= 1'b1;
            addr_reg <= axil_req.awaddr;
         end
         if (w_hit) begin
            w_reg <= 1'b1;
            data_reg <= axil_req.wdata;
         end
         if (aw_reg && w_reg && !axil_rsp.bvalid) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
         end
      end
   end
   // register lands on the edge that raises bvalid, as in the design
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_reg <= 1'b0;
         preset_reg <= PRESET_VARIANT;
         inv_reg <= 1'b0;
      end else if (ce && aw_reg && w_reg && !axil_rsp.bvalid &&
                   addr_reg == `GICL_OFF_CTRL) begin
         low_reg <= data_reg[`GICL_CTRL_LOW_GATE];
         preset_reg <= data_reg[`GICL_CTRL_PRESET];
         inv_reg <= data_reg[`GICL_CTRL_STB_INV];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_prev_reg <= 1'b0;
      end else if (ce) begin
         act_prev_reg <= act;
      end
   end
   // ***********************************************************
   // properties
   // ***********************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   open_follow_a: assert property (
      ce && act && !init |=> level_q == $past(input_pad.data))
      else $error("level view not following data");
   close_capture_a: assert property (
      ce && !init && !act && input_pad.gate_enable_in && act_prev_reg
      |=> edge_q == $past(input_pad.data) && level_q == $past(input_pad.data))
      else $error("closing edge not captured");
   hold_closed_a: assert property (
      ce && !init && !act && !(input_pad.gate_enable_in && act_prev_reg)
      |=> $stable(level_q) && $stable(edge_q))
      else $error("closed latch changed");
   edge_quiet_a: assert property (
      ce && !init && act |=> $stable(edge_q))
      else $error("edge view moved while open");
   init_value_a: assert property (
      ce && init |=> level_q == {`GICL_BANK_W{$past(preset_reg)}} &&
      edge_q == {`GICL_BANK_W{$past(preset_reg)}})
      else $error("init did not load power-on value");
   write_answer_a: assert property (
      ce && aw_hit && w_hit |=> !axil_rsp.bvalid && !axil_rsp.awready
      ##1 axil_rsp.bvalid)
      else $error("write answer late or early");
   read_answer_a: assert property (
      ce && axil_req.arvalid && axil_rsp.arready
      |=> axil_rsp.rvalid && !axil_rsp.arready)
      else $error("read answer not next cycle");
   b_release_a: assert property (
      ce && axil_rsp.bvalid && axil_req.bready
      |=> !axil_rsp.bvalid && axil_rsp.awready && axil_rsp.wready)
      else $error("write response not released");
   r_release_a: assert property (
      ce && axil_rsp.rvalid && axil_req.rready
      |=> !axil_rsp.rvalid && axil_rsp.arready)
      else $error("read response not released");
   freeze_a: assert property (
      !ce |=> $stable(level_q) && $stable(edge_q))
      else $error("views moved with clock enable low");
endmodule

bind gicl_bank gicl_bank_assertions #(.PRESET_VARIANT(PRESET_VARIANT)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .axil_req(axil_req),
   .axil_rsp(axil_rsp), .input_pad(input_pad),
   .global_init_strobe(global_init_strobe), .level_q(level_q),
   .edge_q(edge_q));

/* tb/gicl_pad_model.sv */
// Purpose: pad side model feeding the capture bank
// Assumes: gate rests at the level of low_gate when closed
// Notes: data never rests, so a stale capture shows up
`timescale 1ns/1ps

module gicl_pad_model (
   // clock
   input wire logic aclk,
   // gate sense in use
   input wire logic low_gate,
   // pad lines
   output gicl_pkg::gicl_pad_t pad
);
   initial pad = '0;
   // noisy open phase, last value d held across the close
   task automatic window(input logic [3:0] d, input int n);
      repeat (n) begin
         pad <= '{gate: !low_gate, gate_enable_in: 1'b1, data: 4'($urandom)};
         @(posedge aclk);
      end
      pad.data <= d;
      @(posedge aclk);
      pad.gate <= low_gate;
      @(posedge aclk);
   endtask
   // closed gate; with enable low the gate wiggles but rests at the end
   task automatic idle(input int n, input logic en_in);
      for (int i = 0; i < n; i++) begin
         pad.gate <= (en_in || i == n - 1) ? low_gate : 1'($urandom);
         pad.gate_enable_in <= en_in;
         pad.data <= 4'($urandom);
         @(posedge aclk);
      end
   endtask
endmodule

/* tb/gicl_bank_test.sv */
// Purpose: self-checking bench for the capture latch bank
// Assumes: clear variant at reset, views read back through status
// Notes: expectations queued by the drivers, checked by a monitor
`timescale 1ns/1ps
`include "gicl_params.svh"

module gicl_bank_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic strobe = 1'b0;
   logic low_s = 1'b0;
   logic [3:0] lv = 4'h0, eg = 4'h0, level_q, edge_q;
   gicl_pkg::gicl_axil_req_t req = '0;
   gicl_pkg::gicl_axil_rsp_t rsp;
   gicl_pkg::gicl_pad_t pad;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int err_total = 0, n_compared = 0, n_close = 0;
   always #2.5 aclk = ~aclk;
   gicl_pad_model u_pad (.aclk(aclk), .low_gate(low_s), .pad(pad));
   gicl_bank #(.PRESET_VARIANT(1'b0)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .axil_req(req),
      .axil_rsp(rsp), .input_pad(pad), .global_init_strobe(strobe),
      .level_q(level_q), .edge_q(edge_q));
   // ************************************************************
   // checking
   // ************************************************************
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [31:0] st();
      return {21'h0, pad.gate_enable_in & (pad.gate ^ low_s),
              pad.gate_enable_in, pad.gate, eg, lv};
   endfunction
   always @(posedge aclk) begin
      if (rsp.rvalid && req.rready) begin
         chk("rdata", rq[0][31:0], rsp.rdata);
         chk("rresp", 32'(rq.pop_front() >> 32), rsp.rresp);
      end
      if (rsp.bvalid && req.bready)
         chk("bresp", 32'(bq.pop_front()), rsp.bresp);
   end
   // ************************************************************
   // bus master
   // ************************************************************
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      logic ga, gw;
      ga = 1'b0;
      gw = 1'b0;
      @(posedge aclk);
      bq.push_back(er);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      while (!(ga && gw)) begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) begin
            ga = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (req.wvalid && rsp.wready) begin
            gw = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!rsp.bvalid);
      req.bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
      @(posedge aclk);
      rq.push_back({er, ed});
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
   endtask
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      logic [3:0] d;
      void'($urandom(32'hd0f7_f710));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      chk("level_q", 32'h0000_0000, level_q);
      chk("edge_q", 32'h0000_0000, edge_q);
      axr(`GICL_OFF_CTRL, 32'h0000_0000, `GICL_RESP_OKAY);
      $display("reset test done");
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 6; k++) begin
            d = 4'($urandom);
            u_pad.window(4'($urandom), 1);
            u_pad.window(d, 1 + k % 3);
            lv = d;
            eg = d;
            n_close += 2;
            u_pad.idle(3, 1'b1);
            axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
         end
         u_pad.idle(6, 1'b0);
         axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
         axw(`GICL_OFF_CTRL, 32'(1 - p), `GICL_RESP_OKAY);
         low_s = !p;
         u_pad.idle(2, 1'b0);
      end
      $display("gate test done");
      axr(`GICL_OFF_COUNT, 32'(n_close), `GICL_RESP_OKAY);
      axw(`GICL_OFF_COUNT, 32'h0000_0000, `GICL_RESP_OKAY);
      axr(`GICL_OFF_COUNT, 32'h0000_0000, `GICL_RESP_OKAY);
      axw(8'h10, 32'hffff_ffff, `GICL_RESP_SLVERR);
      axr(8'h10, 32'h0000_0000, `GICL_RESP_SLVERR);
      $display("register test done");
      axw(`GICL_OFF_CTRL, 32'h0000_0002, `GICL_RESP_OKAY);
      @(posedge aclk) strobe <= 1'b1;
      @(posedge aclk) strobe <= 1'b0;
      lv = 4'hf;
      eg = 4'hf;
      axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
      chk("level_q", 32'h0000_000f, level_q);
      axw(`GICL_OFF_CTRL, 32'h0000_0004, `GICL_RESP_OKAY);
      lv = 4'h0;
      eg = 4'h0;
      u_pad.window(4'h5, 2);
      axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
      d = 4'($urandom);
      @(posedge aclk) strobe <= 1'b1;
      u_pad.window(d, 2);
      lv = d;
      eg = d;
      axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
      $display("init test done");
      @(posedge aclk) ce <= 1'b0;
      u_pad.window(~d, 2);
      ce <= 1'b1;
      axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
      chk("edge_q", 32'(d), edge_q);
      $display("freeze test done");
      axw(`GICL_OFF_CTRL, 32'h0000_000e, `GICL_RESP_OKAY);
      lv = 4'hf;
      eg = 4'hf;
      axr(`GICL_OFF_CTRL, 32'h0000_0006, `GICL_RESP_OKAY);
      axr(`GICL_OFF_STATUS, st(), `GICL_RESP_OKAY);
      axr(`GICL_OFF_PAD, {28'h0, ~d}, `GICL_RESP_OKAY);
      $display("soft init test done");
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      $display("watchdog expired");
      tally_and_finish;
   end
endmodule
